/* File: logic/smag_pkg.sv */
// Package for the register access guard: modes, groups, map and register layout
package smag_pkg;

   // CPU privilege modes
   typedef enum logic [2:0] {
      SMAG_MODE_BOOT = 3'h0,
      SMAG_MODE_TEST = 3'h1,
      SMAG_MODE_FW   = 3'h2,
      SMAG_MODE_SYS  = 3'h3,
      SMAG_MODE_USER = 3'h4
   } smag_mode_t;

   // Register groups behind the guard
   typedef enum logic [2:0] {
      SMAG_GRP_CPU_SHARED = 3'h0,
      SMAG_GRP_CPU_BANKED = 3'h1,
      SMAG_GRP_SEGCFG     = 3'h2,
      SMAG_GRP_SYSMGT     = 3'h3,
      SMAG_GRP_FWCFG      = 3'h4,
      SMAG_GRP_HWCOMP     = 3'h5,
      SMAG_GRP_TEST       = 3'h6
   } smag_grp_t;

   // Segment permission codes (rwx bits)
   localparam logic [2:0] SMAG_PERM_NONE = 3'h0;
   localparam logic [2:0] SMAG_PERM_R    = 3'h4;
   localparam logic [2:0] SMAG_PERM_RX   = 3'h5;
   localparam logic [2:0] SMAG_PERM_RW   = 3'h6;
   localparam logic [2:0] SMAG_PERM_RWX  = 3'h7;
   localparam int         SMAG_PERM_RBIT = 2;
   localparam int         SMAG_PERM_WBIT = 1;

   // Register map: address width and selected register addresses
   localparam int          SMAG_AW              = 8;
   localparam logic [7:0]  SMAG_ADDR_CPU_CONTROL_STATUS    = 8'h10;
   localparam logic [7:0]  SMAG_ADDR_CLKSEL     = 8'h80;
   localparam logic [7:0]  SMAG_ADDR_RNG_OUT    = 8'h84;
   localparam logic [7:0]  SMAG_ADDR_KEY_LO     = 8'h90;
   localparam logic [7:0]  SMAG_ADDR_KEY_HI     = 8'h9f;
   localparam logic [7:0]  SMAG_ADDR_HW_BASE    = 8'h80;
   localparam int          SMAG_HW_BITS         = 5;

   // AXI register offsets
   localparam logic [3:0]  SMAG_OFF_FW_LOW      = 4'h0;
   localparam logic [3:0]  SMAG_OFF_FW_HIGH     = 4'h4;
   localparam logic [3:0]  SMAG_OFF_SEGBASE     = 4'h8;
   localparam logic [3:0]  SMAG_OFF_STATUS      = 4'hc;

   // Reset values: restrictive
   localparam logic [15:0] SMAG_RST_FW          = 16'h0000;
   localparam logic [31:0] SMAG_RST_SEGBASE     = 32'h0000_0000;

   // AXI responses
   localparam logic [1:0]  SMAG_RESP_OKAY       = 2'h0;
   localparam logic [1:0]  SMAG_RESP_SLVERR     = 2'h2;

   // Access request from CPU or copy engine
   typedef struct packed {
      logic             valid;
      logic             write;
      logic [7:0]       addr;
      smag_grp_t        grp;
      logic [31:0]      wdata;
      smag_mode_t       mode;
      logic [2:0]       seg_perm;
      logic             seg_tbl_wr;
   } smag_req_t;

   // Result toward the register groups
   typedef struct packed {
      logic             wr_en;
      logic             rd_ok;
      logic             denied;
      logic [7:0]       addr;
      logic [31:0]      wdata;
   } smag_res_t;

endpackage : smag_pkg

/* File: logic/smag_decide.sv */
// Combinational access decision for one register access
`timescale 1ns/1ps
module smag_decide
(
   // Access and attributes
   input  wire smag_pkg::smag_req_t req,
   input  wire logic [31:0]         fw_perm,
   input  wire logic [31:0]         seg_base,
   // Decision
   output logic                     allow_wr,
   output logic                     allow_rd
);
   import smag_pkg::*;

   logic fw_bit;
   logic is_key;
   logic tbl_ok;

   // Firewall permission bit chosen by low address bits of the hw window
   assign fw_bit = fw_perm[req.addr[SMAG_HW_BITS-1:0]];
   assign is_key = (req.addr >= SMAG_ADDR_KEY_LO) && (req.addr <= SMAG_ADDR_KEY_HI);
   // A zero table base disables every segment
   assign tbl_ok = (seg_base != SMAG_RST_SEGBASE);

   // Decision table by group and mode
   always_comb
   begin
      allow_wr = 1'b0;
      allow_rd = 1'b0;
      case (req.grp)
         SMAG_GRP_CPU_SHARED:
         begin
            allow_wr = 1'b1;
            allow_rd = 1'b1;
         end
         SMAG_GRP_CPU_BANKED:
         begin
            // Boot, test and firmware never see banked copies
            allow_wr = (req.mode == SMAG_MODE_SYS) || (req.mode == SMAG_MODE_USER);
            allow_rd = allow_wr;
         end
         SMAG_GRP_SEGCFG:
         begin
            allow_wr = (req.mode == SMAG_MODE_SYS);
            allow_rd = allow_wr;
         end
         SMAG_GRP_SYSMGT:
         begin
            // Writes from system, boot and test modes; reads only the status exception
            allow_wr = (req.mode == SMAG_MODE_SYS) || (req.mode == SMAG_MODE_BOOT)
                       || (req.mode == SMAG_MODE_TEST);
            allow_rd = (req.addr == SMAG_ADDR_CPU_CONTROL_STATUS)
                       && ((req.mode == SMAG_MODE_FW) || (req.mode == SMAG_MODE_USER)
                           || (req.mode == SMAG_MODE_SYS));
         end
         SMAG_GRP_FWCFG:
         begin
            allow_wr = (req.mode != SMAG_MODE_USER) && (req.mode != SMAG_MODE_FW);
            allow_rd = (req.mode != SMAG_MODE_USER);
         end
         SMAG_GRP_HWCOMP:
         begin
            case (req.mode)
               SMAG_MODE_FW:
               begin
                  allow_wr = fw_bit;
                  allow_rd = fw_bit || (req.addr == SMAG_ADDR_CLKSEL);
               end
               SMAG_MODE_USER:
               begin
                  // Segment descriptor of the fetching segment decides
                  allow_wr = tbl_ok && req.seg_perm[SMAG_PERM_WBIT];
                  allow_rd = tbl_ok && req.seg_perm[SMAG_PERM_RBIT];
               end
               default:
               begin
                  allow_wr = 1'b1;
                  allow_rd = 1'b1;
               end
            endcase
            if (req.addr == SMAG_ADDR_RNG_OUT)
            begin
               allow_wr = 1'b0;
            end
            if (is_key)
            begin
               allow_rd = 1'b0;
            end
         end
         SMAG_GRP_TEST:
         begin
            allow_wr = (req.mode == SMAG_MODE_TEST);
            allow_rd = allow_wr;
         end
         default:
         begin
            allow_wr = 1'b0;
            allow_rd = 1'b0;
         end
      endcase
   end

endmodule : smag_decide

/* File: logic/smag_guard.sv */
// Register access guard top: CPU and copy-engine paths plus AXI4-Lite control regs
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Firmware hw access follows firewall registers
// - System mode reaches segment, sysmgt, firewall, hw
// - User hw access follows fetching segment descriptor
// - Copy engine keeps mode latched at start
// - Shared CPU registers open in all modes
// - Banked CPU registers open in system/user
// - Status register readable in firmware and user
// - Clock select readable in firmware always
// - Segment config refused outside system mode
// - Banked registers refused in boot/test/firmware
// - System management reads refused except status
// - Random number output is read only
// - Cipher key registers never read back
// - Restrictive defaults at reset, not overridable
// - Firmware integrity function sees whole EEPROM
// - Other firmware confined by firewall region
// - Exchange RAM controlled by system mode
// - System mode relocates and edits segment table
// - User mode cannot change table base
// - User table edits: seg_tbl_wr unused, segment config writes refused
// - Reset zeroes table base, disabling segments
// - Segment permission codes per memory type
module smag_guard
(
   // Clock and reset
   input  wire  logic                aclk,
   input  wire  logic                aresetn,
   // CPU access
   input  wire  smag_pkg::smag_req_t cpu_req,
   output logic                      cpu_ok_q,
   output smag_pkg::smag_res_t       cpu_res_q,
   // Copy engine access
   input  wire  logic                cpy_start,
   input  wire  logic                cpy_done,
   input  wire  smag_pkg::smag_req_t cpy_req,
   output logic                      cpy_ok_q,
   output smag_pkg::smag_res_t       cpy_res_q,
   // Read data return from register groups
   input  wire  logic [31:0]         grp_rdata,
   output logic [31:0]               cpu_rdata_q,
   // Memory attribute outputs
   output logic [31:0]               seg_base_q,
   output logic                      exch_ram_sys_q,
   output logic                      fw_eeprom_full_q,
   // AXI4-Lite slave
   input  wire  logic [3:0]          s_awaddr,
   input  wire  logic                s_awvalid,
   output logic                      s_awready,
   input  wire  logic [31:0]         s_wdata,
   input  wire  logic [3:0]          s_wstrb,
   input  wire  logic                s_wvalid,
   output logic                      s_wready,
   output logic [1:0]                s_bresp,
   output logic                      s_bvalid,
   input  wire  logic                s_bready,
   input  wire  logic [3:0]          s_araddr,
   input  wire  logic                s_arvalid,
   output logic                      s_arready,
   output logic [31:0]               s_rdata,
   output logic [1:0]                s_rresp,
   output logic                      s_rvalid,
   input  wire  logic                s_rready
);
   import smag_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [15:0] fw_low;
      logic [15:0] fw_high;
      logic [31:0] seg_base;
      logic        cpy_busy;
      smag_mode_t  cpy_mode;
      logic        cpu_ok;
      smag_res_t   cpu_res;
      logic        cpy_ok;
      smag_res_t   cpy_res;
      logic [31:0] cpu_rdata;
      logic        aw_got;
      logic [3:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rd_last_ok;
      logic        attr_on;
   } smag_state_t;

   smag_state_t s_q;
   smag_state_t s_d;

   smag_req_t   cpy_eff;
   logic        cpu_wr;
   logic        cpu_rd;
   logic        cpy_wr;
   logic        cpy_rd;
   logic        bus_sys;

   // ************************************************************
   // Decision instances
   // ************************************************************
   // Copy engine uses the mode latched when the copy started
   always_comb
   begin
      cpy_eff = cpy_req;
      if (s_q.cpy_busy)
      begin
         cpy_eff.mode = s_q.cpy_mode;
      end
   end

   smag_decide u_cpu_dec
   (
      .req      (cpu_req),
      .fw_perm  ({s_q.fw_high, s_q.fw_low}),
      .seg_base (s_q.seg_base),
      .allow_wr (cpu_wr),
      .allow_rd (cpu_rd)
   );

   smag_decide u_cpy_dec
   (
      .req      (cpy_eff),
      .fw_perm  ({s_q.fw_high, s_q.fw_low}),
      .seg_base (s_q.seg_base),
      .allow_wr (cpy_wr),
      .allow_rd (cpy_rd)
   );

   // Control registers are configured only by system-mode software
   assign bus_sys = (cpu_req.mode == SMAG_MODE_SYS);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      s_d = s_q;
      // Attribute outputs rise only once reset has been released
      s_d.attr_on = 1'b1;

      // Copy engine mode latch; start wins over done
      if (cpy_start)
      begin
         s_d.cpy_busy = 1'b1;
         s_d.cpy_mode = cpu_req.mode;
      end
      else if (cpy_done)
      begin
         s_d.cpy_busy = 1'b0;
      end

      // CPU result: refused accesses lose both write and read strobes
      s_d.cpu_ok          = cpu_req.valid && (cpu_req.write ? cpu_wr : cpu_rd);
      s_d.cpu_res.wr_en   = cpu_req.valid && cpu_req.write && cpu_wr;
      s_d.cpu_res.rd_ok   = cpu_req.valid && !cpu_req.write && cpu_rd;
      s_d.cpu_res.denied  = cpu_req.valid && !s_d.cpu_ok;
      s_d.cpu_res.addr    = cpu_req.addr;
      // Write data passes only with a granted write; seg_tbl_wr plays no part
      s_d.cpu_res.wdata   = s_d.cpu_res.wr_en ? cpu_req.wdata : 32'h0000_0000;
      s_d.rd_last_ok      = s_d.cpu_res.rd_ok;
      // Read data of a refused read never leaves as anything but zero
      s_d.cpu_rdata       = s_q.rd_last_ok ? grp_rdata : 32'h0000_0000;

      // Copy engine result
      s_d.cpy_ok          = cpy_req.valid && (cpy_req.write ? cpy_wr : cpy_rd);
      s_d.cpy_res.wr_en   = cpy_req.valid && cpy_req.write && cpy_wr;
      s_d.cpy_res.rd_ok   = cpy_req.valid && !cpy_req.write && cpy_rd;
      s_d.cpy_res.denied  = cpy_req.valid && !s_d.cpy_ok;
      s_d.cpy_res.addr    = cpy_req.addr;
      s_d.cpy_res.wdata   = s_d.cpy_res.wr_en ? cpy_req.wdata : 32'h0000_0000;

      // AXI write channel capture, address and data in either order
      if (s_awready && s_awvalid)
      begin
         s_d.aw_got  = 1'b1;
         s_d.aw_addr = s_awaddr;
      end
      if (s_wready && s_wvalid)
      begin
         s_d.w_got  = 1'b1;
         s_d.w_data = s_wdata;
         s_d.w_strb = s_wstrb;
      end
      if (s_q.bvalid && s_bready)
      begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = bus_sys ? SMAG_RESP_OKAY : SMAG_RESP_SLVERR;
         if (bus_sys)
         begin
            case (s_q.aw_addr)
               SMAG_OFF_FW_LOW:
               begin
                  if (s_q.w_strb[0]) s_d.fw_low[7:0]  = s_q.w_data[7:0];
                  if (s_q.w_strb[1]) s_d.fw_low[15:8] = s_q.w_data[15:8];
               end
               SMAG_OFF_FW_HIGH:
               begin
                  if (s_q.w_strb[0]) s_d.fw_high[7:0]  = s_q.w_data[7:0];
                  if (s_q.w_strb[1]) s_d.fw_high[15:8] = s_q.w_data[15:8];
               end
               SMAG_OFF_SEGBASE:
               begin
                  for (int i = 0; i < 4; i++)
                  begin
                     if (s_q.w_strb[i])
                     begin
                        s_d.seg_base[8*i +: 8] = s_q.w_data[8*i +: 8];
                     end
                  end
               end
               SMAG_OFF_STATUS:
               begin
                  s_d.bresp = SMAG_RESP_OKAY;
               end
               default:
               begin
                  s_d.bresp = SMAG_RESP_SLVERR;
               end
            endcase
         end
      end

      // AXI read
      if (s_q.rvalid && s_rready)
      begin
         s_d.rvalid = 1'b0;
      end
      if (s_arvalid && s_arready)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = SMAG_RESP_OKAY;
         case (s_araddr)
            SMAG_OFF_FW_LOW:  s_d.rdata = {16'h0000, s_q.fw_low};
            SMAG_OFF_FW_HIGH: s_d.rdata = {16'h0000, s_q.fw_high};
            SMAG_OFF_SEGBASE: s_d.rdata = s_q.seg_base;
            SMAG_OFF_STATUS:  s_d.rdata = {28'h0000000, s_q.cpy_mode, s_q.cpy_busy};
            default:
            begin
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = SMAG_RESP_SLVERR;
            end
         endcase
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // Reset loads fixed restrictive values; nothing can preset them
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q          <= '0;
         s_q.fw_low   <= SMAG_RST_FW;
         s_q.fw_high  <= SMAG_RST_FW;
         s_q.seg_base <= SMAG_RST_SEGBASE;
         s_q.cpy_mode <= SMAG_MODE_BOOT;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign cpu_ok_q         = s_q.cpu_ok;
   assign cpu_res_q        = s_q.cpu_res;
   assign cpy_ok_q         = s_q.cpy_ok;
   assign cpy_res_q        = s_q.cpy_res;
   assign cpu_rdata_q      = s_q.cpu_rdata;
   assign seg_base_q       = s_q.seg_base;
   // Exchange RAM owned by system mode, fixed by construction
   assign exch_ram_sys_q   = s_q.attr_on;
   // Firmware EEPROM integrity path spans all of EEPROM once out of reset
   assign fw_eeprom_full_q = s_q.attr_on;
   assign s_awready        = !s_q.aw_got && !s_q.bvalid;
   assign s_wready         = !s_q.w_got && !s_q.bvalid;
   assign s_bvalid         = s_q.bvalid;
   assign s_bresp          = s_q.bresp;
   assign s_arready        = !s_q.rvalid;
   assign s_rvalid         = s_q.rvalid;
   assign s_rdata          = s_q.rdata;
   assign s_rresp          = s_q.rresp;

   // ************************************************************
   // Checks
   // ************************************************************
   sequence cpy_started_s;
      cpy_start && !cpy_done;
   endsequence

   segcfg_sys_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (cpu_req.valid && cpu_req.grp == SMAG_GRP_SEGCFG && cpu_req.mode != SMAG_MODE_SYS)
      |=> !cpu_ok_q) else $error("segment config access granted outside system mode");

   banked_deny_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (cpu_req.valid && cpu_req.grp == SMAG_GRP_CPU_BANKED
       && (cpu_req.mode == SMAG_MODE_BOOT || cpu_req.mode == SMAG_MODE_FW
           || cpu_req.mode == SMAG_MODE_TEST))
      |=> cpu_res_q.denied) else $error("banked register access not refused");

   shared_ok_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (cpu_req.valid && cpu_req.grp == SMAG_GRP_CPU_SHARED) |=> cpu_ok_q)
      else $error("shared cpu register refused");

   rng_ro_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (cpu_req.valid && cpu_req.write && cpu_req.addr == SMAG_ADDR_RNG_OUT)
      |=> !cpu_res_q.wr_en) else $error("random output write passed");

   key_noread_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (cpu_req.valid && !cpu_req.write && cpu_req.grp == SMAG_GRP_HWCOMP
       && cpu_req.addr >= SMAG_ADDR_KEY_LO && cpu_req.addr <= SMAG_ADDR_KEY_HI)
      |=> ##1 cpu_rdata_q == 32'h0000_0000) else $error("key register read back");

   clksel_fw_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (cpu_req.valid && !cpu_req.write && cpu_req.mode == SMAG_MODE_FW
       && cpu_req.grp == SMAG_GRP_HWCOMP && cpu_req.addr == SMAG_ADDR_CLKSEL)
      |=> cpu_res_q.rd_ok) else $error("clock select read refused in firmware");

   cpy_mode_a : assert property (@(posedge aclk) disable iff (!aresetn)
      cpy_started_s ##1 (!cpy_done && !cpy_start)[*3] |-> s_q.cpy_mode == $past(s_q.cpy_mode, 2))
      else $error("copy engine mode changed during copy");

   user_wdeny_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (cpu_req.valid && cpu_req.write && cpu_req.mode == SMAG_MODE_USER
       && cpu_req.grp == SMAG_GRP_HWCOMP && !cpu_req.seg_perm[SMAG_PERM_WBIT])
      |=> !cpu_res_q.wr_en && cpu_res_q.wdata == 32'h0000_0000)
      else $error("user write passed without segment permission");

   segbase_rst_a : assert property (@(posedge aclk)
      !aresetn |=> seg_base_q == SMAG_RST_SEGBASE) else $error("table base not zero after reset");

endmodule : smag_guard

/* File: testbench/smag_grp_model.sv */
// Register group model that answers reads behind the guard
`timescale 1ns/1ps
// ****************
// Read data source
// ****************
module smag_grp_model
(
   // Clock and guard result
   input  wire logic                aclk,
   input  wire smag_pkg::smag_res_t res,
   // Read data toward the guard
   output logic [31:0]              rdata
);
   import smag_pkg::*;
   logic        hold_q = 1'b0;
   logic [7:0]  addr_q = 8'h00;
   logic [31:0] junk_q = 32'h0f0f_0f0f;
   // Answer holds one extra cycle; otherwise the bus churns so no stale word passes
   always_ff @(posedge aclk)
   begin
      hold_q <= res.rd_ok;
      addr_q <= res.rd_ok ? res.addr : addr_q;
      junk_q <= junk_q + 32'h3579_bdf1;
   end
   assign rdata = res.rd_ok ? {24'h5a5a5a, res.addr} :
                  hold_q    ? {24'h5a5a5a, addr_q}   : junk_q;
endmodule : smag_grp_model

/* File: testbench/tb_smag_guard.sv */
// Self-checking bench for the register access guard
`timescale 1ns/1ps
// ****************
// Bench top
// ****************
module tb_smag_guard;
   import smag_pkg::*;
   localparam smag_grp_t  HW = SMAG_GRP_HWCOMP, SM = SMAG_GRP_SYSMGT, SG = SMAG_GRP_SEGCFG;
   localparam smag_mode_t FW = SMAG_MODE_FW, SY = SMAG_MODE_SYS, US = SMAG_MODE_USER;
   logic        aclk = 1'b0, aresetn = 1'b0, cpy_start = 1'b0, cpy_done = 1'b0;
   smag_req_t   cpu_req = '0, cpy_req = '0;
   smag_res_t   cpu_res_q, cpy_res_q;
   smag_mode_t  md;
   logic        cpu_ok_q, cpy_ok_q, exch_ram_sys_q, fw_eeprom_full_q;
   logic [31:0] grp_rdata, cpu_rdata_q, seg_base_q, s_wdata = 32'h0, s_rdata, rd;
   logic [3:0]  s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
   logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
   logic        s_rready = 1'b0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0]  s_bresp, s_rresp, rsp;
   int          fail_count = 0, n_compared = 0, cyc = 0;

   // 100 MHz clock
   always #5 aclk = ~aclk;

   smag_guard u_smag_guard (.aclk, .aresetn, .cpu_req, .cpu_ok_q, .cpu_res_q, .cpy_start,
      .cpy_done, .cpy_req, .cpy_ok_q, .cpy_res_q, .grp_rdata, .cpu_rdata_q, .seg_base_q,
      .exch_ram_sys_q, .fw_eeprom_full_q, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
   smag_grp_model u_smag_grp_model (.aclk, .res(cpu_res_q), .rdata(grp_rdata));

   // Hang guard: the run needs well under a thousand cycles
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One access on the CPU or copy path; the decision shows one cycle later
   task automatic acc(input bit cpy, input smag_grp_t g, input logic [7:0] a,
                      input bit wr, input smag_mode_t m, input logic [2:0] p, input bit ok);
      smag_req_t r;
      smag_req_t c;
      r = '{1'b1, wr, a, g, {24'hc3c3c3, a}, m, p, 1'b0};
      c = cpy ? cpu_req : r;
      c.mode = m;
      @(posedge aclk);
      cpu_req <= c;
      cpy_req <= cpy ? r : cpy_req;
      @(posedge aclk);
      cpu_req.valid <= 1'b0;
      cpy_req.valid <= 1'b0;
      #1;
      chk("grant", cpy ? cpy_ok_q : cpu_ok_q, ok);
      chk("refusal", cpy ? cpy_res_q.denied : cpu_res_q.denied, !ok);
      if (wr && !cpy)
         chk("write data", cpu_res_q.wdata, ok ? r.wdata : 32'h0);
      if (!wr && !cpy)
      begin
         @(posedge aclk);
         #1;
         chk("read data", cpu_rdata_q, ok ? {24'h5a5a5a, a} : 32'h0);
      end
   endtask : acc

   // AXI4-Lite write; address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input smag_mode_t m);
      @(posedge aclk);
      cpu_req.mode <= m;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end
      while (!s_bvalid);
      rsp = s_bresp;
      s_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
      end
      while (!s_rvalid);
      rd = s_rdata;
      rsp = s_rresp;
      s_rready <= 1'b0;
   endtask : axi_rd

   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(SMAG_OFF_FW_LOW);
      chk("firewall reset", rd, 32'h0);
      chk("table base", seg_base_q, 32'h0);
      chk("exchange ram", exch_ram_sys_q, 1'b1);
      chk("full eeprom", fw_eeprom_full_q, 1'b1);
      $display("test reset finished");
      for (int i = 0; i < 5; i++)
      begin
         md = smag_mode_t'(i);
         acc(0, SMAG_GRP_CPU_SHARED, 8'h00, 0, md, 3'h0, 1);
         acc(0, SMAG_GRP_CPU_BANKED, 8'h04, 0, md, 3'h0, md inside {SY, US});
         acc(0, SG, 8'h20, 1, md, 3'h0, md == SY);
      end
      $display("test modes finished");
      acc(0, SM, SMAG_ADDR_CPU_CONTROL_STATUS, 0, FW, 3'h0, 1);
      acc(0, SM, SMAG_ADDR_CPU_CONTROL_STATUS, 0, US, 3'h0, 1);
      acc(0, SM, SMAG_ADDR_CPU_CONTROL_STATUS, 0, SMAG_MODE_BOOT, 3'h0, 0);
      acc(0, SM, 8'h14, 0, FW, 3'h0, 0);
      acc(0, SM, 8'h14, 1, SY, 3'h0, 1);
      acc(0, HW, SMAG_ADDR_CLKSEL, 0, FW, 3'h0, 1);
      acc(0, HW, 8'h83, 1, FW, 3'h0, 0);
      axi_wr(SMAG_OFF_FW_LOW, 32'h0000_0008, SY);
      chk("firewall write", rsp, SMAG_RESP_OKAY);
      acc(0, HW, 8'h83, 1, FW, 3'h0, 1);
      acc(0, HW, 8'h82, 1, FW, 3'h0, 0);
      $display("test firmware finished");
      acc(0, HW, 8'h88, 0, US, SMAG_PERM_R, 0);
      axi_wr(SMAG_OFF_SEGBASE, 32'h0000_1000, US);
      chk("user base write", rsp, SMAG_RESP_SLVERR);
      axi_rd(SMAG_OFF_SEGBASE);
      chk("base kept", rd, 32'h0);
      axi_wr(SMAG_OFF_SEGBASE, 32'h0000_1000, SY);
      chk("system base write", rsp, SMAG_RESP_OKAY);
      axi_rd(SMAG_OFF_SEGBASE);
      chk("base read", rd, 32'h0000_1000);
      chk("base moved", seg_base_q, 32'h0000_1000);
      acc(0, HW, 8'h88, 0, US, SMAG_PERM_R, 1);
      acc(0, HW, 8'h88, 1, US, SMAG_PERM_R, 0);
      acc(0, HW, 8'h88, 1, US, SMAG_PERM_RW, 1);
      acc(0, HW, 8'h88, 0, US, SMAG_PERM_NONE, 0);
      $display("test segment finished");
      acc(0, HW, SMAG_ADDR_RNG_OUT, 1, SY, 3'h0, 0);
      acc(0, HW, SMAG_ADDR_RNG_OUT, 0, SY, 3'h0, 1);
      acc(0, HW, SMAG_ADDR_KEY_LO, 0, SY, 3'h0, 0);
      acc(0, HW, SMAG_ADDR_KEY_HI, 0, US, SMAG_PERM_RWX, 0);
      $display("test hardware finished");
      @(posedge aclk);
      cpu_req.mode <= SY;
      cpy_start <= 1'b1;
      @(posedge aclk);
      cpy_start <= 1'b0;
      acc(1, SG, 8'h20, 1, US, 3'h0, 1);
      axi_rd(SMAG_OFF_STATUS);
      chk("copy status", rd, {28'h0000000, SY, 1'b1});
      @(posedge aclk);
      cpy_done <= 1'b1;
      @(posedge aclk);
      cpy_done <= 1'b0;
      acc(1, SG, 8'h20, 1, US, 3'h0, 0);
      axi_rd(4'h2);
      chk("unmapped resp", rsp, SMAG_RESP_SLVERR);
      chk("unmapped data", rd, 32'h0);
      $display("test copy finished");
      tally_and_finish();
   end
endmodule : tb_smag_guard
